/* include/eeprom_cmd_pkg.sv */
`default_nettype none
package eeprom_cmd_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CMD_INDEX = 6'h02;
    localparam logic [5:0] IDX_STATUS    = 6'h06;
    localparam logic [5:0] IDX_PROTECT   = 6'h09;
    localparam logic [5:0] IDX_OPTION    = 6'h0a;
    localparam logic [5:0] IDX_RESERVED  = 6'h0b;
    localparam logic [5:0] IDX_CMD_HI    = 6'h0c;
    localparam logic [5:0] IDX_CMD_LO    = 6'h0d;
    // Field positions
    localparam int STAT_CMD_COMPLETE = 7;
    localparam int STAT_ACCESS_ERROR = 5;
    localparam int STAT_PROT_VIOL    = 4;
    localparam int PROT_OPEN_BIT     = 7;
    localparam int PROT_SIZE_W       = 6;
    localparam int INDEX_W           = 3;
    localparam int CMD_WORDS         = 6;
    // Configuration field addresses and fault values
    localparam logic [23:0] PROT_CFG_ADDR   = 24'hff_fe0d;
    localparam logic [23:0] OPTION_CFG_ADDR = 24'hff_fe0e;
    localparam logic [5:0]  PROT_FAULT_SIZE = 6'h3f;
    localparam logic [7:0]  OPTION_FAULT    = 8'hff;
    // Reset values held until the configuration read of their field returns
    localparam logic        PROT_OPEN_RST   = 1'h0;
    localparam logic [5:0]  PROT_SIZE_RST   = 6'h3f;
    localparam logic [7:0]  OPTION_RST      = 8'hff;
    // EEPROM window, sectors of 32 bytes
    localparam logic [23:0] EE_BASE         = 24'h10_0000;
    localparam int          EE_SECTOR_SHIFT = 5;
    // Command codes that alter the EEPROM
    localparam logic [7:0]  CMD_EE_BLOCK_ERASE  = 8'h09;
    localparam logic [7:0]  CMD_EE_PROGRAM      = 8'h11;
    localparam logic [7:0]  CMD_EE_SECTOR_ERASE = 8'h12;
    typedef enum logic [2:0] {
        LD_PROT_REQ,
        LD_PROT_WAIT,
        LD_OPT_REQ,
        LD_OPT_WAIT,
        LD_DONE
    } load_state_type;
endpackage
`default_nettype wire

/* verilog/cmd_object_array.sv */
`timescale 1ns/100ps
`default_nettype none
module cmd_object_array #(
    parameter int WORDS = 6
) (
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic [2:0]         index,
    input  wire logic               wr_hi,
    input  wire logic               wr_lo,
    input  wire logic [7:0]         wdata,
    input  wire logic               lock,
    input  wire logic               res_we,
    input  wire logic [2:0]         res_index,
    input  wire logic [15:0]        res_data,
    output logic      [15:0]        rd_word,
    output logic [WORDS-1:0][15:0]  words
);
    if (WORDS < 6 || WORDS > 8) begin : g_check
        $error("cmd_object_array: WORDS must be 6 to 8");
    end

    logic [15:0] mem      [WORDS];
    logic [15:0] next_mem [WORDS];

    ////////////////////////////////////////////////////////////////////////
    // Byte writes from software, word writes of results
    always_comb begin
        for (int i = 0; i < WORDS; i++) begin
            next_mem[i] = mem[i];
            if (res_we && res_index == 3'(i)) begin
                next_mem[i] = res_data; // R18
            end else if (!lock && index == 3'(i)) begin // R17 R21
                if (wr_hi) next_mem[i][15:8] = wdata; // R15
                if (wr_lo) next_mem[i][7:0] = wdata; // R15
            end
        end
    end

    // Storage only
    always_ff @(posedge clk) begin
        for (int i = 0; i < WORDS; i++) begin
            if (srst) mem[i] <= 16'h0000;
            else mem[i] <= next_mem[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Indexed read and flat view for the launch snapshot
    always_comb begin
        rd_word = 16'h0000;
        for (int i = 0; i < WORDS; i++) begin
            words[i] = mem[i];
            if (index == 3'(i)) rd_word = mem[i]; // R23
        end
    end
endmodule // cmd_object_array
`default_nettype wire

/* verilog/eeprom_protect_cmd.sv */
// Function
// R1 - Normal mode: size writes must grow
// R2 - Normal mode: open bit only 1 to 0
// R3 - Open bit set means nothing protected
// R4 - Special mode: protection fields freely writable
// R5 - Reset loads protection byte from configuration
// R6 - Double fault at load: full protection
// R7 - Protected program/erase refused, violation flag set
// R8 - Block erase refused if any protected
// R9 - Protected range is (size+1) times 32 bytes
// R10 - Clearing open bit enables range protection
// R11 - Option register read only
// R12 - Reset loads option byte from configuration
// R13 - Double fault at load: option all ones
// R14 - Reserved register reads zero, ignores writes
// R15 - Six words, every byte readable and writable
// R16 - Writing one to complete flag launches
// R17 - Parameters locked until completion
// R18 - Results readable once complete flag returns
// R19 - Software sets index to words loaded
// R20 - Word 0 code and address high, data after
// R21 - Array writes ignored while busy
// R22 - Software clears error flags before launch
// R23 - Index selects the word accessed
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module eeprom_protect_cmd (
    input  wire logic        SYS_CLK,
    input  wire logic        SRST,
    input  wire logic        MODE_SPECIAL,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             CFG_REQ,
    output logic      [23:0] CFG_ADDR,
    input  wire logic [7:0]  CFG_DATA,
    input  wire logic        CFG_VALID,
    input  wire logic        CFG_DFAULT,
    output logic             CMD_START,
    output logic      [7:0]  CMD_CODE,
    output logic      [23:0] CMD_ADDR,
    output logic      [15:0] CMD_DATA0,
    output logic      [15:0] CMD_DATA1,
    output logic      [15:0] CMD_DATA2,
    output logic      [15:0] CMD_DATA3,
    output logic      [2:0]  CMD_WORD_COUNT,
    input  wire logic        CMD_DONE,
    input  wire logic        CMD_ACCESS_ERROR_FLAG,
    input  wire logic        RES_WE,
    input  wire logic [2:0]  RES_INDEX,
    input  wire logic [15:0] RES_DATA,
    output logic             CMD_IDLE,
    output logic             PROT_OPEN,
    output logic      [5:0]  PROT_SIZE
);
    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Register select from the word index of the bus address
    function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
        return addr[7:2] == idx;
    endfunction

    // True when the address falls in the protected EEPROM range
    function automatic logic is_protected(input logic [23:0] addr,
                                          input logic open,
                                          input logic [5:0] size);
        logic [23:0] offset;
        offset = addr - eeprom_cmd_pkg::EE_BASE;
        if (open) return 1'b0; // R3
        if (addr < eeprom_cmd_pkg::EE_BASE) return 1'b0;
        return (offset >> eeprom_cmd_pkg::EE_SECTOR_SHIFT) <= 24'(size); // R9 R10
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Mode pin synchroniser

    logic mode_meta;
    logic mode_special;

    // Strap pin is asynchronous to the bus clock
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            mode_meta    <= 1'b0;
            mode_special <= 1'b0;
        end else begin
            mode_meta    <= MODE_SPECIAL;
            mode_special <= mode_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    eeprom_cmd_pkg::load_state_type load_state;
    eeprom_cmd_pkg::load_state_type next_load_state;
    logic        next_cfg_req;
    logic [23:0] next_cfg_addr;
    logic        next_prot_open;
    logic [5:0]  next_prot_size;
    logic [7:0]  option_byte;
    logic [7:0]  next_option_byte;
    logic        loaded;

    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        cmd_complete;
    logic        next_cmd_complete;
    logic        access_error;
    logic        next_access_error;
    logic        prot_viol;
    logic        next_prot_viol;
    logic [2:0]  cmd_index;
    logic [2:0]  next_cmd_index;
    logic        next_cmd_start;
    logic [7:0]  next_cmd_code;
    logic [23:0] next_cmd_addr;
    logic [15:0] next_cmd_data [4];
    logic [15:0] cmd_data      [4];
    logic [2:0]  next_cmd_word_count;

    logic        access;
    logic        fire_wr;
    logic        mapped;
    logic        wr_protect;
    logic        wr_status;
    logic        wr_hi;
    logic        wr_lo;
    logic        launch;
    logic        violation;
    logic [15:0] rd_word;
    logic [eeprom_cmd_pkg::CMD_WORDS-1:0][15:0] words;

    assign loaded = load_state == eeprom_cmd_pkg::LD_DONE;
    assign access = PSEL && PENABLE;
    // Writes take effect only at the edge that completes the transfer
    assign fire_wr = access && PREADY && PWRITE;
    assign wr_protect = fire_wr && hit(PADDR, eeprom_cmd_pkg::IDX_PROTECT);
    assign wr_status = fire_wr && hit(PADDR, eeprom_cmd_pkg::IDX_STATUS);
    assign wr_hi = fire_wr && hit(PADDR, eeprom_cmd_pkg::IDX_CMD_HI);
    assign wr_lo = fire_wr && hit(PADDR, eeprom_cmd_pkg::IDX_CMD_LO);
    assign mapped = hit(PADDR, eeprom_cmd_pkg::IDX_CMD_INDEX)
                 || hit(PADDR, eeprom_cmd_pkg::IDX_STATUS)
                 || hit(PADDR, eeprom_cmd_pkg::IDX_PROTECT)
                 || hit(PADDR, eeprom_cmd_pkg::IDX_OPTION)
                 || hit(PADDR, eeprom_cmd_pkg::IDX_RESERVED)
                 || hit(PADDR, eeprom_cmd_pkg::IDX_CMD_HI)
                 || hit(PADDR, eeprom_cmd_pkg::IDX_CMD_LO);

    ////////////////////////////////////////////////////////////////////////
    // Command object storage

    cmd_object_array #(
        .WORDS(eeprom_cmd_pkg::CMD_WORDS)
    ) u_array (
        .clk      (SYS_CLK),
        .srst     (SRST),
        .index    (cmd_index),
        .wr_hi    (wr_hi),
        .wr_lo    (wr_lo),
        .wdata    (PWDATA[7:0]),
        .lock     (!cmd_complete),
        .res_we   (RES_WE),
        .res_index(RES_INDEX),
        .res_data (RES_DATA),
        .rd_word  (rd_word),
        .words    (words)
    );

    ////////////////////////////////////////////////////////////////////////
    // Configuration load and protection register

    // Two phrase reads after reset, then software owns the protection
    always_comb begin
        next_load_state  = load_state;
        next_cfg_req     = 1'b0;
        next_cfg_addr    = CFG_ADDR;
        next_prot_open   = PROT_OPEN;
        next_prot_size   = PROT_SIZE;
        next_option_byte = option_byte;
        unique case (load_state)
            eeprom_cmd_pkg::LD_PROT_REQ: begin
                next_cfg_req    = 1'b1;
                next_cfg_addr   = eeprom_cmd_pkg::PROT_CFG_ADDR; // R5
                next_load_state = eeprom_cmd_pkg::LD_PROT_WAIT;
            end
            eeprom_cmd_pkg::LD_PROT_WAIT: begin
                if (CFG_VALID) begin
                    if (CFG_DFAULT) begin
                        next_prot_open = 1'b0; // R6
                        next_prot_size = eeprom_cmd_pkg::PROT_FAULT_SIZE; // R6
                    end else begin
                        next_prot_open = CFG_DATA[eeprom_cmd_pkg::PROT_OPEN_BIT]; // R5
                        next_prot_size = CFG_DATA[5:0]; // R5
                    end
                    next_load_state = eeprom_cmd_pkg::LD_OPT_REQ;
                end
            end
            eeprom_cmd_pkg::LD_OPT_REQ: begin
                next_cfg_req    = 1'b1;
                next_cfg_addr   = eeprom_cmd_pkg::OPTION_CFG_ADDR; // R12
                next_load_state = eeprom_cmd_pkg::LD_OPT_WAIT;
            end
            eeprom_cmd_pkg::LD_OPT_WAIT: begin
                if (CFG_VALID) begin
                    // R13
                    next_option_byte = CFG_DFAULT ? eeprom_cmd_pkg::OPTION_FAULT : CFG_DATA; // R12
                    next_load_state  = eeprom_cmd_pkg::LD_DONE;
                end
            end
            eeprom_cmd_pkg::LD_DONE: begin
                if (wr_protect) begin
                    if (mode_special) begin
                        next_prot_open = PWDATA[eeprom_cmd_pkg::PROT_OPEN_BIT]; // R4
                        next_prot_size = PWDATA[5:0]; // R4
                    end else begin
                        // Protection may only be added
                        next_prot_open = PROT_OPEN && PWDATA[eeprom_cmd_pkg::PROT_OPEN_BIT]; // R2
                        if (PWDATA[5:0] > PROT_SIZE) next_prot_size = PWDATA[5:0]; // R1
                    end
                end
            end
        endcase
    end

    // Fail safe values until each configuration read returns
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            load_state  <= eeprom_cmd_pkg::LD_PROT_REQ;
            CFG_REQ     <= 1'b0;
            CFG_ADDR    <= 24'h00_0000;
            PROT_OPEN   <= eeprom_cmd_pkg::PROT_OPEN_RST;
            PROT_SIZE   <= eeprom_cmd_pkg::PROT_SIZE_RST;
            option_byte <= eeprom_cmd_pkg::OPTION_RST;
        end else begin
            load_state  <= next_load_state;
            CFG_REQ     <= next_cfg_req;
            CFG_ADDR    <= next_cfg_addr;
            PROT_OPEN   <= next_prot_open;
            PROT_SIZE   <= next_prot_size;
            option_byte <= next_option_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus answer, status flags and command launch

    assign launch = wr_status && PWDATA[eeprom_cmd_pkg::STAT_CMD_COMPLETE] && cmd_complete; // R16

    // Checked against the words as they stand at launch
    always_comb begin
        violation = 1'b0;
        unique case (words[0][15:8])
            eeprom_cmd_pkg::CMD_EE_PROGRAM,
            eeprom_cmd_pkg::CMD_EE_SECTOR_ERASE:
                violation = is_protected({words[0][7:0], words[1]}, PROT_OPEN, PROT_SIZE); // R7
            eeprom_cmd_pkg::CMD_EE_BLOCK_ERASE:
                violation = !PROT_OPEN; // R8
            default:
                violation = 1'b0;
        endcase
    end

    always_comb begin
        next_pready         = access && !PREADY && loaded;
        next_pslverr        = access && !PREADY && loaded && !mapped;
        next_prdata         = PRDATA;
        next_cmd_complete   = cmd_complete;
        next_access_error   = access_error;
        next_prot_viol      = prot_viol;
        next_cmd_index      = cmd_index;
        next_cmd_start      = 1'b0;
        next_cmd_code       = CMD_CODE;
        next_cmd_addr       = CMD_ADDR;
        next_cmd_word_count = CMD_WORD_COUNT;
        for (int i = 0; i < 4; i++) next_cmd_data[i] = cmd_data[i];
        // Read data is captured as the answer is raised
        if (access && !PREADY && loaded && !PWRITE) begin
            next_prdata = 32'h0000_0000;
            if (hit(PADDR, eeprom_cmd_pkg::IDX_STATUS)) begin
                next_prdata[eeprom_cmd_pkg::STAT_CMD_COMPLETE] = cmd_complete;
                next_prdata[eeprom_cmd_pkg::STAT_ACCESS_ERROR] = access_error;
                next_prdata[eeprom_cmd_pkg::STAT_PROT_VIOL]    = prot_viol;
            end else if (hit(PADDR, eeprom_cmd_pkg::IDX_CMD_INDEX)) begin
                next_prdata[2:0] = cmd_index;
            end else if (hit(PADDR, eeprom_cmd_pkg::IDX_PROTECT)) begin
                next_prdata[eeprom_cmd_pkg::PROT_OPEN_BIT] = PROT_OPEN;
                next_prdata[5:0] = PROT_SIZE;
            end else if (hit(PADDR, eeprom_cmd_pkg::IDX_OPTION)) begin
                next_prdata[7:0] = option_byte; // R11
            end else if (hit(PADDR, eeprom_cmd_pkg::IDX_RESERVED)) begin
                next_prdata[7:0] = 8'h00; // R14
            end else if (hit(PADDR, eeprom_cmd_pkg::IDX_CMD_HI)) begin
                // Results hidden while the controller owns the array
                next_prdata[7:0] = cmd_complete ? rd_word[15:8] : 8'h00; // R18 R23
            end else if (hit(PADDR, eeprom_cmd_pkg::IDX_CMD_LO)) begin
                next_prdata[7:0] = cmd_complete ? rd_word[7:0] : 8'h00; // R18 R23
            end
        end
        if (fire_wr && hit(PADDR, eeprom_cmd_pkg::IDX_CMD_INDEX)) begin
            next_cmd_index = PWDATA[2:0];
        end
        // Write one clears; a set in the same cycle wins
        if (wr_status && PWDATA[eeprom_cmd_pkg::STAT_ACCESS_ERROR]) next_access_error = 1'b0;
        if (wr_status && PWDATA[eeprom_cmd_pkg::STAT_PROT_VIOL]) next_prot_viol = 1'b0;
        if (CMD_ACCESS_ERROR_FLAG) next_access_error = 1'b1;
        // Stale error flags block a launch
        if (launch && !access_error && !prot_viol) begin
            if (violation) begin
                next_prot_viol = 1'b1; // R7 R8
            end else begin
                next_cmd_complete   = 1'b0; // R16 R17
                next_cmd_start      = 1'b1; // R16
                next_cmd_code       = words[0][15:8]; // R20
                next_cmd_addr       = {words[0][7:0], words[1]}; // R20
                next_cmd_word_count = cmd_index;
                for (int i = 0; i < 4; i++) next_cmd_data[i] = words[i+2]; // R20
            end
        end
        if (CMD_DONE && !cmd_complete) next_cmd_complete = 1'b1; // R17
    end

    // Idle after reset, command object unlocked
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            PRDATA         <= 32'h0000_0000;
            PREADY         <= 1'b0;
            PSLVERR        <= 1'b0;
            cmd_complete   <= 1'b1;
            access_error   <= 1'b0;
            prot_viol      <= 1'b0;
            cmd_index      <= 3'h0;
            CMD_START      <= 1'b0;
            CMD_CODE       <= 8'h00;
            CMD_ADDR       <= 24'h00_0000;
            CMD_WORD_COUNT <= 3'h0;
            for (int i = 0; i < 4; i++) cmd_data[i] <= 16'h0000;
        end else begin
            PRDATA         <= next_prdata;
            PREADY         <= next_pready;
            PSLVERR        <= next_pslverr;
            cmd_complete   <= next_cmd_complete;
            access_error   <= next_access_error;
            prot_viol      <= next_prot_viol;
            cmd_index      <= next_cmd_index;
            CMD_START      <= next_cmd_start;
            CMD_CODE       <= next_cmd_code;
            CMD_ADDR       <= next_cmd_addr;
            CMD_WORD_COUNT <= next_cmd_word_count;
            for (int i = 0; i < 4; i++) cmd_data[i] <= next_cmd_data[i];
        end
    end

    // Flop outputs under their own names
    assign CMD_IDLE  = cmd_complete;
    assign CMD_DATA0 = cmd_data[0];
    assign CMD_DATA1 = cmd_data[1];
    assign CMD_DATA2 = cmd_data[2];
    assign CMD_DATA3 = cmd_data[3];
endmodule // eeprom_protect_cmd
`default_nettype wire

/* bench/eeprom_protect_cmd_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module eeprom_protect_cmd_checker (
    input wire logic        SYS_CLK,
    input wire logic        SRST,
    input wire logic        MODE_SPECIAL,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        CFG_REQ,
    input wire logic        CFG_VALID,
    input wire logic        CMD_DONE,
    input wire logic        CMD_START,
    input wire logic        CMD_IDLE,
    input wire logic        PROT_OPEN,
    input wire logic [5:0]  PROT_SIZE
);
    // All checks share the one clock domain
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    ////////////////////////////////////////////////////////////////////////////////
    // Mode pin is synced, so look two and three cycles back
    property p_open_grow; $rose(PROT_OPEN) |-> $past(CFG_VALID) || $past(MODE_SPECIAL, 2) || $past(MODE_SPECIAL, 3); endproperty
    a_open_grow: assert property (p_open_grow) else $error("open bit rose in normal mode");
    property p_size_grow; PROT_SIZE < $past(PROT_SIZE) |-> $past(CFG_VALID) || $past(MODE_SPECIAL, 2) || $past(MODE_SPECIAL, 3); endproperty
    a_size_grow: assert property (p_size_grow) else $error("size shrank in normal mode");
    property p_cfg_first; $fell(SRST) |=> CFG_REQ; endproperty
    a_cfg_first: assert property (p_cfg_first) else $error("no configuration request after reset");
    property p_start; $fell(CMD_IDLE) |-> CMD_START; endproperty
    a_start: assert property (p_start) else $error("complete flag cleared without start");
    property p_done; CMD_DONE && !CMD_IDLE |=> CMD_IDLE; endproperty
    a_done: assert property (p_done) else $error("complete flag not returned");
    property p_hold; !CMD_IDLE && !CMD_DONE |=> !CMD_IDLE; endproperty
    a_hold: assert property (p_hold) else $error("complete flag set without done");
    property p_ready; PREADY |=> !PREADY; endproperty
    a_ready: assert property (p_ready) else $error("ready longer than one cycle");
    property p_slverr; PSLVERR |-> PREADY; endproperty
    a_slverr: assert property (p_slverr) else $error("error without ready");
    property p_resv; PREADY && !PWRITE && PADDR == 8'h2c |-> PRDATA == 32'h0; endproperty
    a_resv: assert property (p_resv) else $error("reserved register read nonzero");
    // Main scenarios reached
    c_start: cover property (CMD_START);
    c_err: cover property (PSLVERR);
    c_load: cover property (CFG_VALID);
endmodule // eeprom_protect_cmd_checker
bind eeprom_protect_cmd eeprom_protect_cmd_checker chk_i (.SYS_CLK(SYS_CLK), .SRST(SRST), .MODE_SPECIAL(MODE_SPECIAL),
    .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .CFG_REQ(CFG_REQ),
    .CFG_VALID(CFG_VALID), .CMD_DONE(CMD_DONE), .CMD_START(CMD_START), .CMD_IDLE(CMD_IDLE), .PROT_OPEN(PROT_OPEN),
    .PROT_SIZE(PROT_SIZE));
`default_nettype wire

/* bench/eeprom_protect_cmd_test.sv */
`timescale 1ns/100ps
`default_nettype none
module eeprom_protect_cmd_test;
    logic        SYS_CLK = '0, SRST = '1, MODE_SPECIAL = '0, PSEL = '0, PENABLE = '0, PWRITE = '0, err;
    logic        CFG_VALID = '0, CFG_DFAULT = '0, CMD_DONE = '0, RES_WE = '0, CMD_ACCESS_ERROR_FLAG = '0;
    logic        PREADY, PSLVERR, CFG_REQ, CMD_START, CMD_IDLE, PROT_OPEN;
    logic [7:0]  PADDR = '0, CFG_DATA = '0, CMD_CODE;
    logic [31:0] PWDATA = '0, PRDATA, rd;
    logic [2:0]  RES_INDEX = '0, CMD_WORD_COUNT;
    logic [15:0] RES_DATA = '0, CMD_DATA0, CMD_DATA1, CMD_DATA2, CMD_DATA3;
    logic [23:0] CFG_ADDR, CMD_ADDR;
    logic [5:0]  PROT_SIZE;
    int          errors = 0, checks = 0, k;
    ////////////////////////////////////////////////////////////////////////////////
    // Inputs are driven by the scenario tasks and by the main sequence
    eeprom_protect_cmd dut (.SYS_CLK(SYS_CLK), .SRST(SRST), .MODE_SPECIAL(MODE_SPECIAL), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .CFG_REQ(CFG_REQ), .CFG_ADDR(CFG_ADDR), .CFG_DATA(CFG_DATA), .CFG_VALID(CFG_VALID),
        .CFG_DFAULT(CFG_DFAULT), .CMD_START(CMD_START), .CMD_CODE(CMD_CODE), .CMD_ADDR(CMD_ADDR),
        .CMD_DATA0(CMD_DATA0), .CMD_DATA1(CMD_DATA1), .CMD_DATA2(CMD_DATA2), .CMD_DATA3(CMD_DATA3),
        .CMD_WORD_COUNT(CMD_WORD_COUNT), .CMD_DONE(CMD_DONE), .CMD_ACCESS_ERROR_FLAG(CMD_ACCESS_ERROR_FLAG), .RES_WE(RES_WE),
        .RES_INDEX(RES_INDEX), .RES_DATA(RES_DATA), .CMD_IDLE(CMD_IDLE), .PROT_OPEN(PROT_OPEN), .PROT_SIZE(PROT_SIZE));
    ////////////////////////////////////////////////////////////////////////////////
    // 10 MHz clock
    initial begin
        forever #50 SYS_CLK = ~SYS_CLK;
    end
    task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // One APB transfer; holds everything until ready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        PSEL <= 1'h1; PWRITE <= w; PADDR <= a; PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'h1;
        do @(posedge SYS_CLK); while (PREADY !== 1'h1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'h0; PENABLE <= 1'h0;
    endtask
    // Reset, then answer both configuration reads
    task automatic rst(input logic [7:0] pb, input logic pf, input logic [7:0] ob, input logic of);
        SRST <= 1'h1;
        repeat (20) @(posedge SYS_CLK);
        SRST <= 1'h0;
        for (int i = 0; i < 2; i++) begin
            do @(posedge SYS_CLK); while (CFG_REQ !== 1'h1);
            chk("cfg_addr", CFG_ADDR, i ? 24'hff_fe0e : 24'hff_fe0d);
            CFG_VALID <= 1'h1; CFG_DATA <= i ? ob : pb; CFG_DFAULT <= i ? of : pf;
            @(posedge SYS_CLK);
            CFG_VALID <= 1'h0;
        end
    endtask
    task automatic ld(input logic [2:0] i, input logic [15:0] w);
        apb(1'h1, 8'h08, {29'h0, i});
        apb(1'h1, 8'h30, {24'h0, w[15:8]});
        apb(1'h1, 8'h34, {24'h0, w[7:0]});
    endtask
    task automatic prot(input logic [7:0] wv, input logic [7:0] e);
        apb(1'h1, 8'h24, {24'h0, wv});
        apb(0, 8'h24, '0);
        chk("protection", rd, e);
    endtask
    // Load code and address, launch, judge start or refusal
    task automatic run(input logic [7:0] c, input logic [23:0] a, input logic ok);
        ld(3'h0, {c, a[23:16]});
        ld(3'h1, a[15:0]);
        apb(1'h1, 8'h08, 32'h5);
        apb(1'h1, 8'h18, 32'h80);
        @(negedge SYS_CLK);
        chk("start", CMD_START, ok);
        if (ok) begin
            chk("cmd", {CMD_CODE, CMD_ADDR, 5'h0, CMD_WORD_COUNT}, {c, a, 8'h05});
        end else begin
            apb(0, 8'h18, '0);
            chk("violation", rd[4], 1'h1);
            apb(1'h1, 8'h18, 32'h10);
        end
    endtask
    task automatic done();
        @(posedge SYS_CLK);
        CMD_DONE <= 1'h1;
        @(posedge SYS_CLK);
        CMD_DONE <= 1'h0;
        @(negedge SYS_CLK);
        chk("idle", CMD_IDLE, 1'h1);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the few hundred cycles needed
    initial begin
        #1000000;
        errors++;
        end_of_test();
    end
    // Main sequence
    initial begin
        rst(8'h85, 1'h0, 8'h00, 1'h1);
        chk("load", {PROT_OPEN, PROT_SIZE}, 7'h45);
        apb(1'h1, 8'h28, '0);
        apb(0, 8'h28, '0);
        chk("option", rd, 32'hff);
        apb(1'h1, 8'h2c, 32'hff);
        apb(0, 8'h2c, '0);
        chk("reserved", rd, '0);
        apb(0, 8'h3c, '0);
        chk("unmapped", err, 1'h1);
        prot(8'h83, 8'h85);
        prot(8'h87, 8'h87);
        prot(8'h07, 8'h07);
        prot(8'h88, 8'h08);
        MODE_SPECIAL <= 1'h1;
        repeat (4) @(posedge SYS_CLK);
        prot(8'h80, 8'h80);
        for (k = 2; k < 6; k++) ld(k[2:0], 16'ha0a0 + k[15:0]);
        run(8'h11, 24'h10_0000, 1'h1);
        chk("data", {CMD_DATA0, CMD_DATA1, CMD_DATA2, CMD_DATA3}, 64'ha0a2_a0a3_a0a4_a0a5);
        apb(0, 8'h30, '0);
        chk("busy_read", rd, '0);
        apb(1'h1, 8'h30, 32'hee);
        @(posedge SYS_CLK);
        RES_WE <= 1'h1; RES_INDEX <= 3'h2; RES_DATA <= 16'hbeef;
        @(posedge SYS_CLK);
        RES_WE <= 1'h0;
        done();
        apb(0, 8'h30, '0);
        chk("locked", rd, 32'ha0);
        apb(1'h1, 8'h08, 32'h2);
        apb(0, 8'h30, '0);
        chk("result_hi", rd, 32'hbe);
        apb(0, 8'h34, '0);
        chk("result_lo", rd, 32'hef);
        prot(8'h00, 8'h00);
        run(8'h11, 24'h10_001f, 1'h0);
        run(8'h12, 24'h10_0020, 1'h1);
        done();
        @(posedge SYS_CLK) CMD_ACCESS_ERROR_FLAG <= 1'h1;
        @(posedge SYS_CLK) CMD_ACCESS_ERROR_FLAG <= 1'h0;
        apb(0, 8'h18, '0);
        chk("access_error", rd[5], 1'h1);
        apb(1'h1, 8'h18, 32'h20);
        run(8'h09, 24'h10_0400, 1'h0);
        rst(8'h85, 1'h1, 8'h5a, 1'h0);
        chk("fault", {PROT_OPEN, PROT_SIZE}, 7'h3f);
        apb(0, 8'h28, '0);
        chk("option_load", rd, 32'h5a);
        end_of_test();
    end
endmodule // eeprom_protect_cmd_test
`default_nettype wire
